//--- alarm_panel_config_decode.sv
// Code plug decode, combination keyboard, front panel and trouble display
`timescale 1ns/10ps
module alarm_panel_config_decode
  import alarm_panel_pkg::*;
#(
  parameter int unsigned BEEP_HALF_CYC = BEEP_HALF_CYC_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] combo_plug_high_digits,
  input wire logic [7:0] combo_plug_low_digits,
  input wire logic [7:0] id_plug_a,
  input wire logic [7:0] id_plug_b,
  input wire logic [11:0] key_n,
  input wire logic [3:0] sensor_mode_sw_n,
  input wire logic [3:0] alarm_mode_sw_n,
  input wire logic trouble_btn_n,
  output logic armed_led_n,
  output logic access_led_n,
  output logic [3:0] sensor_mode_led_n,
  output logic [3:0] alarm_mode_led_n,
  output logic [7:0] trouble_digits_n,
  output logic buzzer_n
);

  // Key to digit value; star and pound take the two values above nine
  function automatic logic [3:0] key_value(input logic [11:0] keys);
    logic [3:0] v;
    v = 4'h0;
    for (int i = 0; i < KEY_STAR; i++)
    begin
      if (keys[i])
      begin
        v = 4'(i);
      end
    end
    if (keys[KEY_STAR])
    begin
      v = KEY_STAR_VAL;
    end
    if (keys[KEY_POUND])
    begin
      v = KEY_POUND_VAL;
    end
    return v;
  endfunction

  // Stored digit expected in a given entry state
  function automatic logic [3:0] stored_digit(input entry_state_t s, input logic [15:0] combo);
    logic [3:0] d;
    d = 4'h0;
    case (s)
      ENTRY_D1: d = combo[15:12];
      ENTRY_D2: d = combo[11:8];
      ENTRY_D3: d = combo[7:4];
      ENTRY_D4: d = combo[3:0];
      default: d = 4'h0;
    endcase
    return d;
  endfunction

  localparam int unsigned SYNC_W = 53;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [7:0] plug_hi;
  logic [7:0] plug_lo;
  logic [15:0] id_plugs;
  logic [11:0] keys;
  logic [3:0] sensor_sw;
  logic [3:0] alarm_sw;
  logic trouble_btn;
  logic [15:0] combo;
  logic key_any;
  logic key_prev_q;
  logic key_press;
  logic [3:0] key_val;
  logic digit_match;
  logic combo_ok;
  logic combo_bad;
  entry_state_t entry_q;
  logic access_q;
  logic armed_q;
  logic arming_q;
  logic alarm_fire_q;
  logic alarm_other_q;
  logic combo_ok_seen_q;
  logic combo_bad_seen_q;
  logic [3:0] sensor_mode_q;
  logic [3:0] alarm_mode_q;
  logic btn_prev_q;
  logic btn_press;
  logic shown_q;
  logic [TRB_AW-1:0] disp_idx_q;
  logic [TRB_AW-1:0] wr_ptr_q;
  logic [4:0] trb_count_q;
  logic [7:0] disp_code;
  logic trb_push;
  logic trb_clear;
  logic [15:0] msg_id_q;
  logic id_match;
  logic [7:0] sensor_code_q;
  logic sensor_valid;
  logic [BEEP_CNT_W-1:0] beep_cnt_q;
  logic beep_phase_q;
  logic rd_cap;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  // Two-stage synchroniser for every panel and plug pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
    end
    else
    begin
      sync1_q <= {combo_plug_high_digits, combo_plug_low_digits, id_plug_a, id_plug_b,
                  key_n, sensor_mode_sw_n, alarm_mode_sw_n, trouble_btn_n};
      sync2_q <= sync1_q;
    end
  end

  // Plug bits pass straight through: pull-up gives one once the diode is clipped
  assign plug_hi = sync2_q[52:45];
  assign plug_lo = sync2_q[44:37];
  assign id_plugs = sync2_q[36:21];
  // Panel switches ground their line when closed
  assign keys = ~sync2_q[20:9];
  assign sensor_sw = ~sync2_q[8:5];
  assign alarm_sw = ~sync2_q[4:1];
  assign trouble_btn = ~sync2_q[0];

  // Stored combination as digit1..digit4 from the two plugs
  assign combo = {plug_hi[7:4], plug_hi[3:0], plug_lo[7:4], plug_lo[3:0]};

  // Key press detection on the first key going down
  assign key_any = |keys;
  assign key_press = key_any & ~key_prev_q;
  assign key_val = key_value(keys);
  assign digit_match = (key_val <= DIGIT_MAX) &&
                       (key_val == stored_digit(entry_q, combo));
  assign combo_ok = key_press & digit_match & (entry_q == ENTRY_D4);
  assign combo_bad = key_press & ~digit_match;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_prev_q <= 1'b0;
    end
    else
    begin
      key_prev_q <= key_any;
    end
  end

  // Entry sequencer: each match advances, any mismatch restarts at digit one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      entry_q <= ENTRY_D1;
    end
    else if (key_press)
    begin
      if (!digit_match)
      begin
        entry_q <= ENTRY_D1;
      end
      else
      begin
        case (entry_q)
          ENTRY_D1: entry_q <= ENTRY_D2;
          ENTRY_D2: entry_q <= ENTRY_D3;
          ENTRY_D3: entry_q <= ENTRY_D4;
          ENTRY_D4: entry_q <= ENTRY_D1;
          default: entry_q <= ENTRY_D1;
        endcase
      end
    end
  end

  // APB handshake: one wait state, read data captured with pready
  assign rd_cap = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_PLUGS) ||
                   (paddr == REG_TROUBLE) || (paddr == REG_MSG_ID) || (paddr == REG_SENSOR);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= rd_cap;
      pslverr <= rd_cap & ~addr_ok;
      if (rd_cap && !pwrite)
      begin
        prdata <= rd_mux;
      end
    end
  end

  // Access mode and arming: combination aborts arming, else grants access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      access_q <= 1'b0;
      arming_q <= 1'b0;
      armed_q <= 1'b0;
      alarm_fire_q <= 1'b0;
      alarm_other_q <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == REG_CTRL)
      begin
        armed_q <= pwdata[CTRL_ARMED];
        arming_q <= pwdata[CTRL_ARMING];
        alarm_fire_q <= pwdata[CTRL_FIRE];
        alarm_other_q <= pwdata[CTRL_OTHER];
        if (pwdata[CTRL_ACC_EXIT])
        begin
          access_q <= 1'b0;
        end
      end
      if (combo_ok)
      begin
        if (arming_q)
        begin
          arming_q <= 1'b0;
        end
        else
        begin
          access_q <= 1'b1;
        end
      end
    end
  end

  // Sticky combination outcome flags; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      combo_ok_seen_q <= 1'b0;
      combo_bad_seen_q <= 1'b0;
    end
    else
    begin
      combo_ok_seen_q <= combo_ok |
        (combo_ok_seen_q & ~(wr_en && paddr == REG_STATUS && pwdata[STAT_COMBO_OK]));
      combo_bad_seen_q <= combo_bad |
        (combo_bad_seen_q & ~(wr_en && paddr == REG_STATUS && pwdata[STAT_COMBO_BAD]));
    end
  end

  // Mode switches are only taken while in access mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sensor_mode_q <= 4'h0;
      alarm_mode_q <= 4'h0;
    end
    else if (access_q)
    begin
      sensor_mode_q <= sensor_sw;
      alarm_mode_q <= alarm_sw;
    end
  end

  // Trouble queue: pushes in detection order, button steps through entries
  assign trb_push = wr_en && (paddr == REG_TROUBLE) && !pwdata[TRB_CLEAR] &&
                    (trb_count_q != TRB_FULL);
  assign trb_clear = wr_en && (paddr == REG_TROUBLE) && pwdata[TRB_CLEAR];
  assign btn_press = trouble_btn & ~btn_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q <= '0;
      trb_count_q <= 5'h00;
      disp_idx_q <= '0;
      shown_q <= 1'b0;
      btn_prev_q <= 1'b0;
    end
    else
    begin
      btn_prev_q <= trouble_btn;
      if (trb_clear)
      begin
        wr_ptr_q <= '0;
        trb_count_q <= 5'h00;
        disp_idx_q <= '0;
        shown_q <= 1'b0;
      end
      else
      begin
        if (trb_push)
        begin
          wr_ptr_q <= wr_ptr_q + 1'b1;
          trb_count_q <= trb_count_q + 1'b1;
        end
        if (btn_press && trb_count_q != 5'h00)
        begin
          if (!shown_q)
          begin
            shown_q <= 1'b1;
            disp_idx_q <= '0;
          end
          else if ({1'b0, disp_idx_q} + 5'h01 >= trb_count_q)
          begin
            disp_idx_q <= '0;
          end
          else
          begin
            disp_idx_q <= disp_idx_q + 1'b1;
          end
        end
      end
    end
  end

  trouble_code_mem u_trouble_mem (
    .pclk(pclk),
    .wr_en(trb_push),
    .wr_addr(wr_ptr_q),
    .wr_data(pwdata[7:0]),
    .rd_addr(disp_idx_q),
    .rd_data(disp_code)
  );

  // Identity check of a received message and sensor type code decode
  assign id_match = (msg_id_q == id_plugs);
  assign sensor_valid = (sensor_code_q[7:4] >= CLASS_EXTERNAL) &&
                        (sensor_code_q[7:4] <= CLASS_ENTRANCE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msg_id_q <= 16'h0000;
      sensor_code_q <= 8'h00;
    end
    else if (wr_en)
    begin
      if (paddr == REG_MSG_ID)
      begin
        msg_id_q <= pwdata[15:0];
      end
      if (paddr == REG_SENSOR)
      begin
        sensor_code_q <= pwdata[7:0];
      end
    end
  end

  // Buzzer beat generator for the intermittent fire pattern
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      beep_cnt_q <= '0;
      beep_phase_q <= 1'b0;
    end
    else if (beep_cnt_q >= BEEP_CNT_W'(BEEP_HALF_CYC - 1))
    begin
      beep_cnt_q <= '0;
      beep_phase_q <= ~beep_phase_q;
    end
    else
    begin
      beep_cnt_q <= beep_cnt_q + 1'b1;
    end
  end

  // Panel outputs, low to light
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_led_n <= 1'b1;
      access_led_n <= 1'b1;
      sensor_mode_led_n <= 4'hf;
      alarm_mode_led_n <= 4'hf;
      trouble_digits_n <= 8'hff;
      buzzer_n <= 1'b1;
    end
    else
    begin
      armed_led_n <= ~armed_q;
      access_led_n <= ~access_q;
      sensor_mode_led_n <= (access_q || trouble_btn) ? ~sensor_mode_q : 4'hf;
      alarm_mode_led_n <= (access_q || trouble_btn) ? ~alarm_mode_q : 4'hf;
      trouble_digits_n <= (trouble_btn && shown_q) ? ~disp_code : 8'hff;
      if (alarm_mode_q == ALARM_MODE_REMOTE)
      begin
        buzzer_n <= 1'b1;
      end
      else if (alarm_fire_q)
      begin
        buzzer_n <= ~beep_phase_q;
      end
      else
      begin
        buzzer_n <= ~alarm_other_q;
      end
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rd_mux = {28'h0000000, alarm_other_q, alarm_fire_q, arming_q, armed_q};
      REG_STATUS: rd_mux = {16'h0000, alarm_mode_q, sensor_mode_q, entry_q, 1'b0,
                            combo_bad_seen_q, combo_ok_seen_q, arming_q, armed_q, access_q};
      REG_PLUGS: rd_mux = {id_plugs, plug_hi, plug_lo};
      REG_TROUBLE: rd_mux = {11'h000, shown_q, disp_code, 3'h0, trb_count_q, disp_idx_q};
      REG_MSG_ID: rd_mux = {15'h0000, id_match, msg_id_q};
      REG_SENSOR: rd_mux = {16'h0000, sensor_valid, 3'(sensor_code_q[7:4] - CLASS_EXTERNAL),
                            sensor_code_q[3:0], sensor_code_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

endmodule

//--- alarm_panel_pkg.sv
// Constants, register map and field layout for the alarm panel block
package alarm_panel_pkg;

  // Clock and buzzer timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BEEP_HALF_MS = 250;
  localparam int unsigned BEEP_HALF_CYC_DEF = (CLK_HZ / 1000) * BEEP_HALF_MS;
  localparam int unsigned BEEP_CNT_W = 23;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_PLUGS = 12'h008;
  localparam logic [11:0] REG_TROUBLE = 12'h00c;
  localparam logic [11:0] REG_MSG_ID = 12'h010;
  localparam logic [11:0] REG_SENSOR = 12'h014;

  // Control register bits
  localparam int unsigned CTRL_ARMED = 0;
  localparam int unsigned CTRL_ARMING = 1;
  localparam int unsigned CTRL_FIRE = 2;
  localparam int unsigned CTRL_OTHER = 3;
  localparam int unsigned CTRL_ACC_EXIT = 4;

  // Status register bits (write one clears the two sticky bits)
  localparam int unsigned STAT_COMBO_OK = 3;
  localparam int unsigned STAT_COMBO_BAD = 4;

  // Trouble register: bit 8 set on write empties the queue
  localparam int unsigned TRB_CLEAR = 8;
  localparam int unsigned TRB_DEPTH = 16;
  localparam int unsigned TRB_AW = 4;
  localparam logic [4:0] TRB_FULL = 5'h10;

  // Combination digits and keys
  localparam logic [3:0] KEY_STAR_VAL = 4'ha;
  localparam logic [3:0] KEY_POUND_VAL = 4'hb;
  localparam logic [3:0] DIGIT_MAX = 4'hb;
  localparam int unsigned KEY_STAR = 10;
  localparam int unsigned KEY_POUND = 11;

  // Sensor type code classes
  localparam logic [3:0] CLASS_EXTERNAL = 4'h4;
  localparam logic [3:0] CLASS_ENTRANCE = 4'h8;

  // One-hot alarm mode switch position meaning remote alarm
  localparam logic [3:0] ALARM_MODE_REMOTE = 4'h8;

  // Combination entry states, Gray coded along the digit sequence
  typedef enum logic [1:0] {
    ENTRY_D1 = 2'b00,
    ENTRY_D2 = 2'b01,
    ENTRY_D3 = 2'b11,
    ENTRY_D4 = 2'b10
  } entry_state_t;

endpackage

//--- trouble_code_mem.sv
// Small trouble code memory with registered read data
`timescale 1ns/10ps
module trouble_code_mem
  import alarm_panel_pkg::*;
(
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [TRB_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [TRB_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [TRB_DEPTH];

  // Write port
  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge pclk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

//--- alarm_panel_monitor.sv
// Port level assertions for the alarm panel block
`timescale 1ns/10ps
module alarm_panel_monitor
  import alarm_panel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trouble_btn_n,
  input wire logic armed_led_n,
  input wire logic access_led_n,
  input wire logic [3:0] sensor_mode_led_n,
  input wire logic [3:0] alarm_mode_led_n,
  input wire logic [7:0] trouble_digits_n,
  input wire logic buzzer_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answer timing and error reporting
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside second access cycle");
  ready_second_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // Outputs are dark right after reset; lamps and buzzer are low active
  reset_dark_a: assert property ($rose(presetn) |-> !pready && armed_led_n && access_led_n
    && buzzer_n && trouble_digits_n == 8'hff)
    else $error("outputs not idle after reset");
  // Display and mode lamps stay dark when neither button nor access asks for them
  trouble_blank_a: assert property (trouble_btn_n [*5] |-> trouble_digits_n == 8'hff)
    else $error("trouble display lit with button released");
  mode_dark_a: assert property ((trouble_btn_n && access_led_n) [*5] |->
    sensor_mode_led_n == 4'hf && alarm_mode_led_n == 4'hf)
    else $error("mode lamps lit outside access or button");
endmodule

//--- panel_user_model.sv
// Keyboard, rotary switches, button and code plugs facing the panel block
`timescale 1ns/10ps
module panel_user_model (
  input wire logic pclk,
  output logic [7:0] combo_plug_high_digits,
  output logic [7:0] combo_plug_low_digits,
  output logic [7:0] id_plug_a,
  output logic [7:0] id_plug_b,
  output logic [11:0] key_n,
  output logic [3:0] sensor_mode_sw_n,
  output logic [3:0] alarm_mode_sw_n,
  output logic trouble_btn_n
);
  // Idle panel: nothing pressed, plugs clipped for 1976
  initial
  begin
    combo_plug_high_digits = 8'h19;
    combo_plug_low_digits = 8'h76;
    id_plug_a = 8'h5a;
    id_plug_b = 8'hc3;
    key_n = 12'hfff;
    sensor_mode_sw_n = 4'hf;
    alarm_mode_sw_n = 4'hf;
    trouble_btn_n = 1'b1;
  end
  // A clipped lead floats to the pull-up and reads one
  task automatic set_plugs(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge pclk);
    combo_plug_high_digits <= hi;
    combo_plug_low_digits <= lo;
    repeat (4) @(posedge pclk);
  endtask
  // A press grounds its own line; index 12 is the trouble button
  task automatic press(input int k);
    @(posedge pclk);
    if (k == 12)
      trouble_btn_n <= 1'b0;
    else
      key_n <= ~(12'h1 << k);
    repeat (8) @(posedge pclk);
  endtask
  task automatic release_all();
    @(posedge pclk);
    key_n <= 12'hfff;
    trouble_btn_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // Rotary positions are one-hot, closed contact low
  task automatic set_sw(input int s, input int a);
    @(posedge pclk);
    sensor_mode_sw_n <= ~(4'h1 << s);
    alarm_mode_sw_n <= ~(4'h1 << a);
    repeat (6) @(posedge pclk);
  endtask
endmodule

//--- alarm_panel_config_decode_tb.sv
// Register, keyboard and panel scenarios for the alarm panel block
`timescale 1ns/10ps
module alarm_panel_config_decode_tb;
  import alarm_panel_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trouble_btn_n;
  logic armed_led_n, access_led_n, buzzer_n, e;
  logic [11:0] paddr, key_n;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] combo_plug_high_digits, combo_plug_low_digits, id_plug_a, id_plug_b;
  logic [3:0] sensor_mode_sw_n, alarm_mode_sw_n, sensor_mode_led_n, alarm_mode_led_n, cl, un;
  logic [7:0] trouble_digits_n;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;

  alarm_panel_config_decode #(.BEEP_HALF_CYC(8)) dut (.*);
  panel_user_model partner (.*);

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits for pready; only the hang guard ends a wait that never sees it
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let an edge pass so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(rd & m, exp);
  endtask
  // Four keys, first key in the top nibble
  task automatic combo(input logic [15:0] c);
    for (int i = 3; i >= 0; i--)
    begin
      partner.press(int'(c[i*4 +: 4]));
      partner.release_all();
    end
  endtask
  // Buzzer activity over 40 cycles as {low seen, high seen}
  task automatic buzz(input logic [31:0] ctl, input logic [7:0] exp);
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    apb(1'b1, REG_CTRL, ctl);
    repeat (4) @(posedge pclk);
    repeat (40)
    begin
      @(posedge pclk);
      if (buzzer_n === 1'b0)
        lo++;
      else if (buzzer_n === 1'b1)
        hi++;
    end
    chk8({6'h0, lo > 0, hi > 0}, exp);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(REG_CTRL, 32'hffffffff, 32'h0);
    rchk(REG_STATUS, 32'hffffffff, 32'h0);
    rchk(REG_PLUGS, 32'hffffffff, 32'h5ac31976);
    apb(1'b0, 12'h018, 32'h0);
    chk32({rd[30:0], e}, 32'h1);
    apb(1'b1, REG_MSG_ID, 32'h5ac3);
    rchk(REG_MSG_ID, 32'h10000, 32'h10000);
    apb(1'b1, REG_MSG_ID, 32'h5ac2);
    rchk(REG_MSG_ID, 32'h10000, 32'h0);
    // Every sensor class, then a code outside them with unit zero
    for (int c = 4; c <= 9; c++)
    begin
      cl = c[3:0];
      un = (c == 9) ? 4'h0 : 4'(c * 3);
      apb(1'b1, REG_SENSOR, {24'h0, cl, un});
      rchk(REG_SENSOR, 32'hffff, {16'h0, c < 9, 3'(cl - 4'h4), un, cl, un});
    end
    buzz(32'h4, 8'h3);
    buzz(32'h8, 8'h2);
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk8({7'h0, armed_led_n}, 8'h0);
    // Wrong first digit, then mismatch on the third, then the right one
    combo(16'h9195);
    combo(16'h1976);
    rchk(REG_STATUS, 32'h19, 32'h19);
    chk8({7'h0, access_led_n}, 8'h0);
    apb(1'b1, REG_STATUS, 32'h18);
    rchk(REG_STATUS, 32'h18, 32'h0);
    partner.set_sw(1, 3);
    rchk(REG_STATUS, 32'hff00, 32'h8200);
    chk8({sensor_mode_led_n, alarm_mode_led_n}, 8'hd7);
    apb(1'b1, REG_CTRL, 32'h10);
    partner.set_sw(2, 0);
    rchk(REG_STATUS, 32'hff01, 32'h8200);
    chk8({sensor_mode_led_n, alarm_mode_led_n}, 8'hff);
    partner.press(12);
    chk8({sensor_mode_led_n, alarm_mode_led_n}, 8'hd7);
    partner.release_all();
    buzz(32'h8, 8'h1);
    // Star and pound digits abort arming instead of granting access
    partner.set_plugs(8'h2a, 8'hb4);
    apb(1'b1, REG_CTRL, 32'h2);
    combo(16'h2ab4);
    rchk(REG_CTRL, 32'h2, 32'h0);
    rchk(REG_STATUS, 32'h1, 32'h0);
    // Codes come back in arrival order and wrap
    apb(1'b1, REG_TROUBLE, 32'h12);
    apb(1'b1, REG_TROUBLE, 32'h34);
    apb(1'b1, REG_TROUBLE, 32'h56);
    rchk(REG_TROUBLE, 32'h1f0, 32'h30);
    for (int i = 0; i < 4; i++)
    begin
      partner.press(12);
      chk8(trouble_digits_n, ~(8'(24'h123456 >> (16 - 8 * (i % 3)))));
      partner.release_all();
    end
    chk8(trouble_digits_n, 8'hff);
    apb(1'b1, REG_TROUBLE, 32'h100);
    rchk(REG_TROUBLE, 32'h1f0, 32'h0);
    wrap_up();
  end
endmodule

bind alarm_panel_config_decode alarm_panel_monitor mon (.*);
